// ===== boot_loader_pkg.sv
/*
  Shared constants of the boot loader packet engine: link bytes, command
  codes, packet lengths, status codes and state encodings.
  Assumes nothing of its surroundings; the packet engine refers to it by
  boot_loader_pkg::name.
*/
`default_nettype none

package boot_loader_pkg;

  // link-level answer bytes
  localparam logic [7:0] ACK_BYTE = 8'hcc;
  localparam logic [7:0] NAK_BYTE = 8'h33;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // command codes, first payload byte
  localparam logic [7:0] CMD_PING = 8'h20;
  localparam logic [7:0] CMD_DOWNLOAD = 8'h21;
  localparam logic [7:0] CMD_RUN = 8'h22;
  localparam logic [7:0] CMD_QUERY_RESULT = 8'h23;
  localparam logic [7:0] CMD_SEND_DATA = 8'h24;
  localparam logic [7:0] CMD_RESET = 8'h25;

  // packet lengths, counting length and sum bytes
  localparam logic [7:0] HDR_BYTES = 8'h02;
  localparam logic [7:0] LEN_MIN = 8'h03;
  localparam logic [7:0] LEN_DOWNLOAD = 8'h0b;
  localparam logic [7:0] LEN_RUN = 8'h07;
  localparam logic [7:0] LEN_RESP = 8'h03;

  // payload byte positions of the 32-bit arguments, msb first
  localparam int ARG0_POS = 1;
  localparam int ARG1_POS = 5;

  // last-command status codes; values are arbitrary
  localparam logic [7:0] STATUS_SUCCESS = 8'h40;
  localparam logic [7:0] STATUS_UNKNOWN_CMD = 8'h41;
  localparam logic [7:0] STATUS_INVALID_CMD = 8'h42;
  localparam logic [7:0] STATUS_FLASH_FAIL = 8'h43;

  // serial interface lock
  typedef enum logic [1:0] {
    LINK_NONE = 2'h0,
    LINK_UART = 2'h1,
    LINK_SSI = 2'h2
  } link_t;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_SUM = 10'h002,
    ST_BODY = 10'h004,
    ST_CHECK = 10'h008,
    ST_ERASE = 10'h010,
    ST_PROG = 10'h020,
    ST_ACK = 10'h040,
    ST_ACT = 10'h080,
    ST_RESP = 10'h100,
    ST_HOST_ACK = 10'h200
  } eng_state_t;

endpackage

`default_nettype wire

// ===== byte_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset; DEPTH is a
  power of two so the pointers wrap on their own.
*/
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("byte_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign o_in_ready = (count_q != (AW+1)'(DEPTH));
  assign o_out_valid = (count_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // storage carries no reset; only the pointers define content
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== boot_packet_engine.sv
/*
  Packet engine of a serial boot loader: takes framed host packets from a
  UART or SSI byte stream, checks them, answers ACK/NAK, runs the ping,
  query, download, send-data, run and reset commands, sends replies.
  Assumes byte-level link front ends on i_mclk with valid/ready, an SSI
  front end already set to clock_phase_setting = clock_polarity_setting = 1
  that shifts zeros when nothing is offered, and a flash controller that
  answers each request with a one-cycle i_flash_done.
*/
// Notes on behaviour
// R1: first byte is the whole packet length
// R2: second byte is mod-256 sum of payload
// R3: answer 0xcc on good packet, else 0x33
// R4: ack tells reception only, not command validity
// R5: host polls for first non-zero answer byte
// R6: reply bytes follow length byte without gaps
// R7: host acks or naks every reply packet
// R8: after its nak host resends the command
// R9: drop zero bytes while awaiting host answer
// R10: ssi host clocks zeros to fetch replies
// R11: first payload byte is the command code
// R12: ping only sets status to success
// R13: query replies one byte holding last status
// R14: download carries address then count, msb first
// R15: download erases region before its ack
// R16: send data programs at auto-advancing address
// R17: host sends at most eight data bytes
// R18: programming stops when download count reached
// R19: naked send data leaves address unchanged
// R20: send data only after download or itself; the code also keeps it open after a query
// R21: run acks first, then jumps to address
// R22: reset acks first, then soft reset
// R23: first used interface locks out the other
// R24: ssi is spi mode with phase, polarity one
// R25: nak bad sum or length below three
`default_nettype none

module boot_packet_engine #(
  parameter int MAX_PAYLOAD = 9,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_uart_rx_valid,
  input wire logic [7:0] i_uart_rx_data,
  output logic o_uart_rx_ready,
  input wire logic i_ssi_rx_valid,
  input wire logic [7:0] i_ssi_rx_data,
  output logic o_ssi_rx_ready,
  output logic o_uart_tx_valid,
  output logic o_ssi_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_uart_tx_ready,
  input wire logic i_ssi_tx_ready,
  output logic o_erase_req,
  output logic o_prog_req,
  output logic [31:0] o_flash_addr,
  output logic [31:0] o_erase_len,
  output logic [7:0] o_prog_data,
  input wire logic i_flash_done,
  input wire logic i_flash_err,
  output logic o_run_req,
  output logic [31:0] o_run_addr,
  output logic o_soft_reset
);

  localparam int IW = $clog2(MAX_PAYLOAD);
  localparam int ARG0 = boot_loader_pkg::ARG0_POS;
  localparam int ARG1 = boot_loader_pkg::ARG1_POS;

  generate
    if (MAX_PAYLOAD < 9 || MAX_PAYLOAD > 253) begin : g_bad
      $error("boot_packet_engine: MAX_PAYLOAD must lie in 9..253");
    end
  endgenerate

  boot_loader_pkg::eng_state_t state_q, state_d;
  boot_loader_pkg::link_t link_q;

  logic fifo_in_ready;
  logic fifo_in_valid;
  logic [7:0] fifo_in_data;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_ready;
  logic rx_fire;
  logic uart_take;
  logic ssi_take;

  logic [7:0] len_q;
  logic [7:0] sum_q;
  logic [7:0] acc_q;
  logic [7:0] cnt_q;
  logic [7:0] buf_q [MAX_PAYLOAD];
  logic good_q;
  logic [7:0] status_q;
  logic [31:0] addr_q;
  logic [31:0] remain_q;
  logic prog_active_q;
  logic [7:0] idx_q;
  logic [1:0] resp_idx_q;

  logic tx_busy;
  logic tx_done;
  logic tx_can;
  logic tx_load;
  logic [7:0] tx_byte;

  logic [7:0] cmd;
  logic [7:0] data_len;
  logic pkt_good;
  logic prog_more;

  // interface lock and input steering
  // before the lock, zeros are swallowed so idle ssi padding cannot claim it
  assign uart_take = i_uart_rx_valid &&
    (link_q == boot_loader_pkg::LINK_NONE || link_q == boot_loader_pkg::LINK_UART);
  assign ssi_take = i_ssi_rx_valid && !uart_take && // R23
    (link_q == boot_loader_pkg::LINK_NONE || link_q == boot_loader_pkg::LINK_SSI);
  assign fifo_in_data = uart_take ? i_uart_rx_data : i_ssi_rx_data;
  assign fifo_in_valid = (uart_take || ssi_take) &&
    (link_q != boot_loader_pkg::LINK_NONE || fifo_in_data != boot_loader_pkg::ZERO_BYTE);
  // the locked-out interface is drained and dropped
  assign o_uart_rx_ready = (link_q == boot_loader_pkg::LINK_SSI) || fifo_in_ready; // R23
  assign o_ssi_rx_ready = (link_q == boot_loader_pkg::LINK_UART) ||
    (fifo_in_ready && !(link_q == boot_loader_pkg::LINK_NONE && i_uart_rx_valid)); // R23

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_q <= boot_loader_pkg::LINK_NONE;
    end else if (link_q == boot_loader_pkg::LINK_NONE && fifo_in_valid && fifo_in_ready) begin
      link_q <= uart_take ? boot_loader_pkg::LINK_UART : boot_loader_pkg::LINK_SSI; // R23
    end
  end

  // rx buffering; the engine stalls it during erase and programming
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_in_valid(fifo_in_valid),
    .i_in_data(fifo_in_data),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(rx_valid),
    .o_out_data(rx_byte),
    .i_out_ready(rx_ready)
  );

  assign rx_ready = (state_q == boot_loader_pkg::ST_IDLE) ||
    (state_q == boot_loader_pkg::ST_SUM) || (state_q == boot_loader_pkg::ST_BODY) ||
    (state_q == boot_loader_pkg::ST_HOST_ACK);
  assign rx_fire = rx_valid && rx_ready;

  // decode helpers
  assign cmd = buf_q[0];
  assign data_len = len_q - boot_loader_pkg::LEN_MIN;
  assign pkt_good = (len_q >= boot_loader_pkg::LEN_MIN) && (acc_q == sum_q); // R2 R25
  assign prog_more = (remain_q != '0) && (idx_q <= data_len); // R18

  // tx side: one byte register, valid routed to the locked link
  assign tx_busy = o_uart_tx_valid || o_ssi_tx_valid;
  assign tx_done = (o_uart_tx_valid && i_uart_tx_ready) || (o_ssi_tx_valid && i_ssi_tx_ready);
  // a new byte may load in the cycle the old one leaves, so replies run gapless
  assign tx_can = !tx_busy || tx_done; // R6

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_uart_tx_valid <= 1'b0;
      o_ssi_tx_valid <= 1'b0;
      o_tx_data <= '0;
    end else if (tx_load) begin
      o_uart_tx_valid <= (link_q == boot_loader_pkg::LINK_UART);
      o_ssi_tx_valid <= (link_q == boot_loader_pkg::LINK_SSI);
      o_tx_data <= tx_byte;
    end else if (tx_done) begin
      o_uart_tx_valid <= 1'b0;
      o_ssi_tx_valid <= 1'b0;
    end
  end

  // sequencing
  always_comb begin
    state_d = state_q;
    tx_load = 1'b0;
    tx_byte = boot_loader_pkg::ZERO_BYTE;
    unique case (state_q)
      boot_loader_pkg::ST_IDLE: begin
        if (rx_fire && rx_byte != boot_loader_pkg::ZERO_BYTE) begin
          state_d = boot_loader_pkg::ST_SUM; // R1
        end
      end
      boot_loader_pkg::ST_SUM: begin
        if (rx_fire) begin
          state_d = (len_q > boot_loader_pkg::HDR_BYTES) ?
            boot_loader_pkg::ST_BODY : boot_loader_pkg::ST_CHECK;
        end
      end
      boot_loader_pkg::ST_BODY: begin
        if (rx_fire && (cnt_q + 8'h01) == (len_q - boot_loader_pkg::HDR_BYTES)) begin
          state_d = boot_loader_pkg::ST_CHECK; // R2
        end
      end
      boot_loader_pkg::ST_CHECK: begin
        state_d = boot_loader_pkg::ST_ACK;
        if (pkt_good && cmd == boot_loader_pkg::CMD_DOWNLOAD &&
            len_q == boot_loader_pkg::LEN_DOWNLOAD) begin
          state_d = boot_loader_pkg::ST_ERASE; // R15
        end else if (pkt_good && cmd == boot_loader_pkg::CMD_SEND_DATA && prog_active_q &&
                     data_len <= 8'(MAX_PAYLOAD - 1)) begin
          state_d = boot_loader_pkg::ST_PROG; // R16
        end
      end
      boot_loader_pkg::ST_ERASE: begin
        if (i_flash_done) begin
          state_d = boot_loader_pkg::ST_ACK; // R15
        end
      end
      boot_loader_pkg::ST_PROG: begin
        if (!o_prog_req && !prog_more) begin
          state_d = boot_loader_pkg::ST_ACK; // R18
        end
      end
      boot_loader_pkg::ST_ACK: begin
        if (tx_can) begin
          tx_load = 1'b1;
          tx_byte = good_q ? boot_loader_pkg::ACK_BYTE : boot_loader_pkg::NAK_BYTE; // R3 R4
          state_d = boot_loader_pkg::ST_IDLE;
          if (good_q && cmd == boot_loader_pkg::CMD_QUERY_RESULT) begin
            state_d = boot_loader_pkg::ST_RESP; // R13
          end else if (good_q && (cmd == boot_loader_pkg::CMD_RESET ||
                       (cmd == boot_loader_pkg::CMD_RUN &&
                        len_q == boot_loader_pkg::LEN_RUN))) begin
            state_d = boot_loader_pkg::ST_ACT; // R21 R22
          end
        end
      end
      boot_loader_pkg::ST_ACT: begin
        // act only once the ack byte has left
        if (!tx_busy) begin
          state_d = boot_loader_pkg::ST_IDLE; // R21 R22
        end
      end
      boot_loader_pkg::ST_RESP: begin
        if (tx_can) begin
          tx_load = 1'b1;
          tx_byte = (resp_idx_q == 2'h0) ? boot_loader_pkg::LEN_RESP : status_q; // R1 R2 R13
          if (resp_idx_q == 2'h2) begin
            state_d = boot_loader_pkg::ST_HOST_ACK; // R6
          end
        end
      end
      boot_loader_pkg::ST_HOST_ACK: begin
        // either answer ends the reply; after a nak the host repeats the query
        if (rx_fire && rx_byte != boot_loader_pkg::ZERO_BYTE) begin
          state_d = boot_loader_pkg::ST_IDLE; // R9
        end
      end
      default: begin
        state_d = boot_loader_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= boot_loader_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // packet capture
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      len_q <= '0;
      sum_q <= '0;
      acc_q <= '0;
      cnt_q <= '0;
    end else if (rx_fire) begin
      if (state_q == boot_loader_pkg::ST_IDLE) begin
        len_q <= rx_byte; // R1
      end
      if (state_q == boot_loader_pkg::ST_SUM) begin
        sum_q <= rx_byte; // R2
        acc_q <= '0;
        cnt_q <= '0;
      end
      if (state_q == boot_loader_pkg::ST_BODY) begin
        acc_q <= acc_q + rx_byte; // R2
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // payload store; bytes past the buffer still count toward the sum
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < MAX_PAYLOAD; i++) begin
        buf_q[i] <= '0;
      end
    end else if (rx_fire && state_q == boot_loader_pkg::ST_BODY &&
                 cnt_q < 8'(MAX_PAYLOAD)) begin
      buf_q[cnt_q[IW-1:0]] <= rx_byte; // R11
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      good_q <= 1'b0;
    end else if (state_q == boot_loader_pkg::ST_CHECK) begin
      good_q <= pkt_good; // R25
    end
  end

  // last-command status; a naked packet leaves it as it was
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_q <= boot_loader_pkg::STATUS_SUCCESS;
    end else if (state_q == boot_loader_pkg::ST_CHECK && pkt_good) begin
      unique case (cmd)
        boot_loader_pkg::CMD_PING: status_q <= boot_loader_pkg::STATUS_SUCCESS; // R12
        boot_loader_pkg::CMD_QUERY_RESULT: status_q <= status_q; // R13
        boot_loader_pkg::CMD_RESET: status_q <= boot_loader_pkg::STATUS_SUCCESS;
        boot_loader_pkg::CMD_DOWNLOAD: begin
          status_q <= (len_q == boot_loader_pkg::LEN_DOWNLOAD) ?
            boot_loader_pkg::STATUS_SUCCESS : boot_loader_pkg::STATUS_INVALID_CMD;
        end
        boot_loader_pkg::CMD_RUN: begin
          status_q <= (len_q == boot_loader_pkg::LEN_RUN) ?
            boot_loader_pkg::STATUS_SUCCESS : boot_loader_pkg::STATUS_INVALID_CMD;
        end
        boot_loader_pkg::CMD_SEND_DATA: begin
          status_q <= (prog_active_q && data_len <= 8'(MAX_PAYLOAD - 1)) ?
            boot_loader_pkg::STATUS_SUCCESS : boot_loader_pkg::STATUS_INVALID_CMD; // R20
        end
        default: status_q <= boot_loader_pkg::STATUS_UNKNOWN_CMD;
      endcase
    end else if ((state_q == boot_loader_pkg::ST_ERASE || state_q == boot_loader_pkg::ST_PROG) &&
                 i_flash_done && i_flash_err) begin
      status_q <= boot_loader_pkg::STATUS_FLASH_FAIL;
    end
  end

  // program window and address
  // address moves only on a good download or while a good send-data packet is programmed
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_q <= '0;
      remain_q <= '0;
      prog_active_q <= 1'b0;
    end else if (state_q == boot_loader_pkg::ST_CHECK && pkt_good &&
                 cmd == boot_loader_pkg::CMD_DOWNLOAD &&
                 len_q == boot_loader_pkg::LEN_DOWNLOAD) begin
      addr_q <= {buf_q[ARG0], buf_q[ARG0 + 1], buf_q[ARG0 + 2], buf_q[ARG0 + 3]}; // R14
      remain_q <= {buf_q[ARG1], buf_q[ARG1 + 1], buf_q[ARG1 + 2], buf_q[ARG1 + 3]}; // R14
      prog_active_q <= 1'b0;
    end else if (state_q == boot_loader_pkg::ST_ERASE && i_flash_done) begin
      prog_active_q <= !i_flash_err;
    end else if (state_q == boot_loader_pkg::ST_PROG && o_prog_req && i_flash_done) begin
      addr_q <= addr_q + 32'h0000_0001; // R16 R19
      remain_q <= remain_q - 32'h0000_0001; // R18
    end else if (state_q == boot_loader_pkg::ST_CHECK && pkt_good &&
                 cmd != boot_loader_pkg::CMD_SEND_DATA &&
                 cmd != boot_loader_pkg::CMD_QUERY_RESULT) begin
      prog_active_q <= 1'b0; // R20
    end
  end

  // flash requests; each is held until the controller's done pulse
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_erase_req <= 1'b0;
      o_prog_req <= 1'b0;
      o_flash_addr <= '0;
      o_erase_len <= '0;
      o_prog_data <= '0;
      idx_q <= '0;
    end else begin
      if (state_q == boot_loader_pkg::ST_CHECK) begin
        idx_q <= 8'h01;
        if (state_d == boot_loader_pkg::ST_ERASE) begin
          o_erase_req <= 1'b1; // R15
          o_flash_addr <= {buf_q[ARG0], buf_q[ARG0 + 1], buf_q[ARG0 + 2], buf_q[ARG0 + 3]};
          o_erase_len <= {buf_q[ARG1], buf_q[ARG1 + 1], buf_q[ARG1 + 2], buf_q[ARG1 + 3]};
        end
      end
      if (i_flash_done) begin
        o_erase_req <= 1'b0;
        o_prog_req <= 1'b0;
      end
      if (state_q == boot_loader_pkg::ST_PROG && !o_prog_req && prog_more) begin
        o_prog_req <= 1'b1; // R16
        o_flash_addr <= addr_q;
        o_prog_data <= buf_q[idx_q[IW-1:0]];
        idx_q <= idx_q + 8'h01;
      end
    end
  end

  // reply byte counter
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      resp_idx_q <= '0;
    end else if (state_q != boot_loader_pkg::ST_RESP) begin
      resp_idx_q <= '0;
    end else if (tx_can) begin
      resp_idx_q <= resp_idx_q + 2'h1;
    end
  end

  // run and reset leave after the ack; reset is held by the outside reset
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_run_req <= 1'b0;
      o_run_addr <= '0;
      o_soft_reset <= 1'b0;
    end else begin
      o_run_req <= 1'b0;
      o_soft_reset <= 1'b0;
      if (state_q == boot_loader_pkg::ST_ACT && !tx_busy) begin
        if (cmd == boot_loader_pkg::CMD_RUN) begin
          o_run_req <= 1'b1; // R21
          o_run_addr <= {buf_q[ARG0], buf_q[ARG0 + 1], buf_q[ARG0 + 2], buf_q[ARG0 + 3]};
        end else begin
          o_soft_reset <= 1'b1; // R22
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== boot_engine_checker.sv
/*
  Concurrent checks on the boot packet engine's outputs.
  Assumes one clock, active-low async reset; bound below to the engine.
*/
`default_nettype none
module boot_engine_checker (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic o_uart_tx_valid,
  input wire logic o_ssi_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic i_uart_tx_ready,
  input wire logic o_erase_req,
  input wire logic o_prog_req,
  input wire logic [31:0] o_flash_addr,
  input wire logic [7:0] o_prog_data,
  input wire logic i_flash_done,
  input wire logic o_run_req,
  input wire logic o_soft_reset
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic [31:0] last_q;
  logic seq_q;
  // a fresh erase starts a new address run
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      last_q <= 32'h0;
      seq_q <= 1'b0;
    end else if (o_erase_req) begin
      seq_q <= 1'b0;
    end else if (o_prog_req && i_flash_done) begin
      last_q <= o_flash_addr;
      seq_q <= 1'b1;
    end
  end
  tx_hold_a: assert property (o_uart_tx_valid && !i_uart_tx_ready
    |=> o_uart_tx_valid && $stable(o_tx_data)) else $error("tx byte not held");
  tx_excl_a: assert property (!(o_uart_tx_valid && o_ssi_tx_valid))
    else $error("both links transmit");
  erase_hold_a: assert property (o_erase_req && !i_flash_done
    |=> o_erase_req && $stable(o_flash_addr)) else $error("erase request dropped");
  prog_hold_a: assert property (o_prog_req && !i_flash_done
    |=> o_prog_req && $stable(o_prog_data)) else $error("program request dropped");
  prog_step_a: assert property (o_prog_req && seq_q
    && !($past(o_prog_req) && !$past(i_flash_done))
    |-> o_flash_addr == last_q + 32'h1) else $error("program address not advanced by one");
  req_excl_a: assert property (!(o_erase_req && o_prog_req))
    else $error("erase and program together");
  run_pulse_a: assert property (o_run_req |-> !o_uart_tx_valid ##1 !o_run_req)
    else $error("run pulse wrong");
  reset_pulse_a: assert property (o_soft_reset |-> !o_uart_tx_valid ##1 !o_soft_reset)
    else $error("soft reset pulse wrong");
  erase_c: cover property (o_erase_req && i_flash_done);
  prog_c: cover property (o_prog_req && i_flash_done);
  run_c: cover property (o_run_req);
endmodule
bind boot_packet_engine boot_engine_checker chk (.i_mclk, .i_arst_n, .o_uart_tx_valid,
  .o_ssi_tx_valid, .o_tx_data, .i_uart_tx_ready, .o_erase_req, .o_prog_req, .o_flash_addr,
  .o_prog_data, .i_flash_done, .o_run_req, .o_soft_reset);
`default_nettype wire

// ===== host_link_model.sv
/*
  Host side of the byte link: sends queued bytes, collects every reply byte.
  Assumes valid/ready byte ports on one clock; driven at the falling edge.
*/
`default_nettype none
module host_link_model (
  input wire logic i_mclk,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  input wire logic i_slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic took;
  logic [1:0] div;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_tx_ready = 1'b1;
    took = 1'b0;
    div = 2'h0;
  end
  always @(posedge i_mclk) begin
    took = o_rx_valid && i_rx_ready;
    if (i_tx_valid && o_tx_ready) got_q.push_back(i_tx_data);
  end
  always @(negedge i_mclk) begin
    div = div + 2'h1;
    o_tx_ready = !i_slow || (div == 2'h0); // slow host stalls three cycles in four
    if (took) void'(send_q.pop_front());
    if (send_q.size() > 0) begin
      o_rx_valid = 1'b1;
      o_rx_data = send_q[0];
    end else begin
      o_rx_valid = 1'b0;
      o_rx_data = ~o_rx_data; // idle line inverts every bit of its last value each cycle
    end
  end
endmodule
`default_nettype wire

// ===== serial_boot_loader_packet_protocol_bench.sv
/*
  Self-checking bench of the boot packet engine over its UART side.
  Assumes the host model beside it and a flash that answers in three cycles.
*/
`default_nettype none
module serial_boot_loader_packet_protocol_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_arst_n, ssi_v, slow, done, uv, urdy, srdy, utv, stv, er, pr, run, srst;
  logic srst_seen, full_seen, stx_seen, slow_rdy;
  logic [7:0] ssi_d, ud, txd, pd;
  logic [31:0] fa, el, ra, er_a, er_l, run_a;
  logic [39:0] prog_q[$];
  logic [7:0] pl[$];
  int error_cnt, compares, cyc, fcnt;
  host_link_model host (.i_mclk(i_mclk), .o_rx_valid(uv), .o_rx_data(ud), .i_rx_ready(urdy),
    .i_tx_valid(utv), .i_tx_data(txd), .o_tx_ready(slow_rdy), .i_slow(slow));
  boot_packet_engine dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_uart_rx_valid(uv),
    .i_uart_rx_data(ud), .o_uart_rx_ready(urdy), .i_ssi_rx_valid(ssi_v), .i_ssi_rx_data(ssi_d),
    .o_ssi_rx_ready(srdy), .o_uart_tx_valid(utv), .o_ssi_tx_valid(stv), .o_tx_data(txd),
    .i_uart_tx_ready(slow_rdy), .i_ssi_tx_ready(1'b1), .o_erase_req(er), .o_prog_req(pr),
    .o_flash_addr(fa), .o_erase_len(el), .o_prog_data(pd), .i_flash_done(done),
    .i_flash_err(1'b0), .o_run_req(run), .o_run_addr(ra), .o_soft_reset(srst));
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  always @(negedge i_mclk) begin
    if (done) done = 1'b0;
    else if (er || pr) begin
      fcnt++;
      if (fcnt == 3) begin
        done = 1'b1;
        fcnt = 0;
        if (pr) prog_q.push_back({fa, pd});
        else begin
          er_a = fa;
          er_l = el;
        end
      end
    end
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (run) run_a = ra;
    if (srst) srst_seen = 1'b1;
    if (!urdy) full_seen = 1'b1;
    if (stv) stx_seen = 1'b1;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic bad);
    logic [7:0] s;
    s = 8'h00;
    foreach (pl[i]) s += pl[i];
    host.send_q.push_back(8'h00);
    host.send_q.push_back(8'(pl.size() + 2));
    host.send_q.push_back(s ^ {7'h0, bad});
    foreach (pl[i]) host.send_q.push_back(pl[i]);
  endtask
  task automatic get_chk(input logic [7:0] exp);
    for (int k = 0; k < 2000 && host.got_q.size() == 0; k++) @(negedge i_mclk);
    check(host.got_q.size() > 0 ? {24'h0, host.got_q.pop_front()} : 32'hffff_ffff, {24'h0, exp});
  endtask
  task automatic t_query(input logic [7:0] st, input logic [7:0] ans = 8'hcc);
    pl = '{8'h23};
    send(1'b0);
    get_chk(8'hcc);
    get_chk(8'h03);
    get_chk(st);
    get_chk(st);
    host.send_q.push_back(8'h00);
    host.send_q.push_back(ans);
  endtask
  task automatic t_bad();
    pl = '{8'h20};
    send(1'b1);
    get_chk(8'h33);
    pl = '{};
    send(1'b0);
    get_chk(8'h33);
    pl = '{8'h26};
    send(1'b0);
    get_chk(8'hcc);
    t_query(8'h41, 8'h33);
    t_query(8'h41);
    pl = '{8'h20};
    send(1'b0);
    get_chk(8'hcc);
    t_query(8'h40);
  endtask
  task automatic t_load();
    er_a = 32'h0;
    pl = '{8'h21, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05};
    send(1'b0);
    get_chk(8'hcc);
    check(er_a, 32'h0000_1000);
    check(er_l, 32'h0000_0005);
    pl = '{8'h24, 8'ha0, 8'ha1, 8'ha2};
    send(1'b0);
    get_chk(8'hcc);
    pl = '{8'h24, 8'hb0};
    send(1'b1);
    get_chk(8'h33);
    pl = '{8'h24, 8'ha3, 8'ha4, 8'ha5};
    send(1'b0);
    get_chk(8'hcc);
    t_query(8'h40);
    check(prog_q.size(), 5);
    foreach (prog_q[i]) check({24'h0, prog_q[i][7:0]}, 32'ha0 + i);
    foreach (prog_q[i]) check(prog_q[i][39:8], 32'h1000 + i);
  endtask
  task automatic t_lock();
    logic [7:0] b[3];
    b = '{8'h03, 8'h20, 8'h20};
    for (int i = 0; i < 3; i++) begin
      ssi_v = 1'b1;
      ssi_d = b[i];
      #1 check(srdy, 1'b1);
      @(negedge i_mclk);
    end
    ssi_v = 1'b0;
    repeat (20) @(negedge i_mclk);
    check(stx_seen, 1'b0);
    check(host.got_q.size(), 0);
  endtask
  task automatic t_burst();
    slow = 1'b1;
    pl = '{8'h20};
    repeat (16) send(1'b0);
    repeat (16) get_chk(8'hcc);
    check(full_seen, 1'b1);
    slow = 1'b0;
  endtask
  task automatic t_run_reset();
    pl = '{8'h22, 8'h12, 8'h34, 8'h56, 8'h78};
    send(1'b0);
    get_chk(8'hcc);
    repeat (10) @(negedge i_mclk);
    check(run_a, 32'h1234_5678);
    pl = '{8'h25};
    send(1'b0);
    get_chk(8'hcc);
    repeat (10) @(negedge i_mclk);
    check(srst_seen, 1'b1);
    i_arst_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_arst_n = 1'b1;
    pl = '{8'h20};
    send(1'b0);
    get_chk(8'hcc);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    i_arst_n = 1'b0;
    {ssi_v, slow, done, srst_seen, full_seen, stx_seen} = '0;
    ssi_d = 8'h00;
    {error_cnt, compares, cyc, fcnt} = '0;
    repeat (4) @(negedge i_mclk);
    i_arst_n = 1'b1;
    t_bad();
    t_load();
    t_lock();
    t_burst();
    t_run_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
